// File: rtl/dc_line_buffer.sv
// Purpose: Four-entry 64-bit store for returned read bursts
// Assumes: One write port and one read port, same clock
// Notes: Read data come out of a register one cycle after rdEn
`timescale 1ns/10ps
`default_nettype none
module dc_line_buffer (
   // Clock
   input wire logic clk,
   // Write side
   input wire logic wrEn,
   input wire logic [1:0] wrAddr,
   input wire logic [63:0] wrData,
   // Read side
   input wire logic rdEn,
   input wire logic [1:0] rdAddr,
   output logic [63:0] rdData
);
   logic [63:0] mem [0:3];

   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      if (rdEn) begin
         rdData <= mem[rdAddr];
      end
   end
endmodule : dc_line_buffer
`default_nettype wire

// File: rtl/dc_sdram_defines.svh
// Purpose: Constants for the display cache SDRAM controller
// Assumes: 25 MHz controller clock
// Notes: Power-up and refresh counts are in controller clock periods; timing parameters in memory clock periods
`ifndef DC_SDRAM_DEFINES_SVH
`define DC_SDRAM_DEFINES_SVH

`define DC_CLK_NS 40
`define DC_POWERUP_NS 100000
`define DC_POWERUP_CYC ((`DC_POWERUP_NS + `DC_CLK_NS - 1) / `DC_CLK_NS)
`define DC_REFI_NS 15600
`define DC_REFI_CYC (`DC_REFI_NS / `DC_CLK_NS)
`define DC_REF_SLACK 128
`define DC_MEM_MHZ 133
`define DC_DIV_FAST 3'h2
`define DC_DIV_SLOW 3'h4
`define DC_T_RP 4'h3
`define DC_T_RCD 4'h3
`define DC_T_RC 4'h8
`define DC_T_MRD 4'h2
`define DC_T_WR 4'h2
`define DC_CL 4'h3
`define DC_INIT_REFS 2'h2
`define DC_MODE_WORD 12'h031
`define DC_PRE_ALL 12'h400
`define DC_FIFO_DEPTH 3'h4
`define DC_CMD_NOP 4'h7
`define DC_CMD_DESEL 4'hf
`define DC_CMD_ACT 4'h3
`define DC_CMD_READ 4'h5
`define DC_CMD_WRITE 4'h4
`define DC_CMD_PRE 4'h2
`define DC_CMD_REF 4'h1
`define DC_CMD_MRS 4'h0

`endif

// File: rtl/dc_sdram_pkg.sv
// Purpose: Types for the display cache SDRAM controller
// Assumes: Nothing
// Notes: Numeric constants live in dc_sdram_defines.svh
package dc_sdram_pkg;
   typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_REF, CMD_MRS} cmd_t;
   typedef enum logic [3:0] {S_OFF, S_PWRUP, S_INITREF, S_MODE, S_IDLE, S_WRITE, S_WR1, S_READ, S_CAP0, S_CAP1,
      S_PRE, S_WAIT} state_t;
endpackage : dc_sdram_pkg

// File: rtl/display_cache_sdram_ctrl.sv
// Purpose: Display cache controller for a 32-bit single-rank SDR SDRAM channel
// Assumes: Single 25 MHz clock; memory clock made by a divider selected by the strap
// Notes: One transaction at a time, two-beat bursts, precharge after every access
`timescale 1ns/10ps
`default_nettype none
`include "dc_sdram_defines.svh"
module display_cache_sdram_ctrl import dc_sdram_pkg::*; (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Strap and configuration levels
   input wire logic sbaStrap,
   input wire logic displaySelect,
   input wire logic localMemPresent,
   input wire logic renderLocal,
   input wire logic [1:0] waitStates,
   // Engine requests
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [21:2] reqAddr,
   input wire logic [63:0] reqWrData,
   input wire logic [7:0] reqMask,
   output logic reqReady,
   // Read return
   output logic rdValid,
   output logic [63:0] rdData,
   input wire logic rdReady,
   // System memory arbitration
   input wire logic texReq,
   input wire logic renderSysReq,
   output logic texGrant,
   output logic renderSysGrant,
   // Memory pins
   output logic lmChipSelectN,
   output logic lmRowStrobeN,
   output logic lmColStrobeN,
   output logic lmWriteEnableN,
   output logic [7:0] lmByteMask,
   output logic [11:0] lmAddrBus,
   output logic [31:0] lmDataBusOut,
   output logic lmDataBusOe,
   input wire logic [31:0] lmDataBusIn,
   output logic [1:0] lmWriteClock,
   output logic lmReadTimingClock
);
   function automatic logic [3:0] cmdPins(input cmd_t c);
      case (c)
         CMD_ACT: cmdPins = `DC_CMD_ACT;
         CMD_READ: cmdPins = `DC_CMD_READ;
         CMD_WRITE: cmdPins = `DC_CMD_WRITE;
         CMD_PRE: cmdPins = `DC_CMD_PRE;
         CMD_REF: cmdPins = `DC_CMD_REF;
         CMD_MRS: cmdPins = `DC_CMD_MRS;
         default: cmdPins = `DC_CMD_NOP;
      endcase
   endfunction : cmdPins

   function automatic logic [11:0] rowMap(input logic [21:2] a);
      rowMap = {a[10], a[11], a[21:12]};
   endfunction : rowMap

   function automatic logic [11:0] colMap(input logic [21:2] a);
      colMap = {a[10], 3'h0, a[9:2]};
   endfunction : colMap

   state_t state_q, state_d, ret_q, ret_d;
   cmd_t cmd;
   logic [3:0] pins_q, pins_d;
   logic [2:0] divCnt_q, divCnt_d, div;
   logic clk_q, clk_d, freqSel_q, freqSel_d, memTick;
   logic [3:0] waitCnt_q, waitCnt_d;
   logic [11:0] initCnt_q, initCnt_d;
   logic [8:0] refCnt_q, refCnt_d;
   logic refDue_q, refDue_d, refDone, modeDone_q, modeDone_d;
   logic [1:0] refLeft_q, refLeft_d;
   logic [21:2] cur_q, cur_d;
   logic [63:0] wrData_q, wrData_d;
   logic [7:0] mask_q, mask_d, byteMask_q, byteMask_d;
   logic [11:0] addr_q, addr_d;
   logic [31:0] dout_q, dout_d, beat0_q, beat0_d;
   logic oe_q, oe_d, ready_q, ready_d, push, pop;
   logic [2:0] fifoCount_q, fifoCount_d;
   logic [1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
   logic rdValid_q, rdValid_d;
   logic [3:0] ws;

   assign ws = {2'h0, waitStates};
   assign div = freqSel_q ? `DC_DIV_FAST : `DC_DIV_SLOW;
   assign memTick = (divCnt_q == 3'h0);

   always_comb begin
      // Strap is caught in every reset cycle, so the last one before release holds
      freqSel_d = reset ? sbaStrap : freqSel_q;
      divCnt_d = (divCnt_q >= div - 3'h1) ? 3'h0 : divCnt_q + 3'h1;
      clk_d = (divCnt_d >= (div >> 1));
      state_d = state_q;
      ret_d = ret_q;
      waitCnt_d = waitCnt_q;
      initCnt_d = initCnt_q;
      refLeft_d = refLeft_q;
      modeDone_d = modeDone_q;
      cur_d = cur_q;
      wrData_d = wrData_q;
      mask_d = mask_q;
      beat0_d = beat0_q;
      pins_d = pins_q;
      addr_d = addr_q;
      dout_d = dout_q;
      oe_d = oe_q;
      byteMask_d = byteMask_q;
      cmd = CMD_NOP;
      refDone = 1'b0;
      push = 1'b0;
      if (state_q == S_PWRUP && initCnt_q != 12'h0) begin
         initCnt_d = initCnt_q - 12'h1;
      end
      if (memTick) begin
         oe_d = 1'b0;
         case (state_q)
            S_OFF: begin
               if (displaySelect && localMemPresent) begin
                  state_d = S_PWRUP;
                  initCnt_d = 12'(`DC_POWERUP_CYC);
               end
            end
            S_PWRUP: begin
               if (initCnt_q == 12'h0) begin
                  cmd = CMD_PRE;
                  addr_d = `DC_PRE_ALL;
                  waitCnt_d = `DC_T_RP - 4'h1;
                  refLeft_d = `DC_INIT_REFS;
                  ret_d = S_INITREF;
                  state_d = S_WAIT;
               end
            end
            S_INITREF: begin
               cmd = CMD_REF;
               refLeft_d = refLeft_q - 2'h1;
               waitCnt_d = `DC_T_RC - 4'h1;
               ret_d = (refLeft_q == 2'h1) ? S_MODE : S_INITREF;
               state_d = S_WAIT;
            end
            S_MODE: begin
               cmd = CMD_MRS;
               addr_d = `DC_MODE_WORD;
               waitCnt_d = `DC_T_MRD - 4'h1;
               modeDone_d = 1'b1;
               ret_d = S_IDLE;
               state_d = S_WAIT;
            end
            S_IDLE: begin
               if (refDue_q) begin
                  cmd = CMD_REF;
                  refDone = 1'b1;
                  waitCnt_d = `DC_T_RC - 4'h1;
                  ret_d = S_IDLE;
                  state_d = S_WAIT;
               end else if (reqValid && ready_q) begin
                  cmd = CMD_ACT;
                  cur_d = reqAddr;
                  wrData_d = reqWrData;
                  mask_d = reqMask;
                  addr_d = rowMap(reqAddr);
                  waitCnt_d = `DC_T_RCD - 4'h1 + ws;
                  ret_d = reqWrite ? S_WRITE : S_READ;
                  state_d = S_WAIT;
               end
            end
            S_WRITE: begin
               cmd = CMD_WRITE;
               addr_d = colMap(cur_q);
               oe_d = 1'b1;
               dout_d = wrData_q[31:0];
               byteMask_d = {2{mask_q[3:0]}};
               state_d = S_WR1;
            end
            S_WR1: begin
               oe_d = 1'b1;
               dout_d = wrData_q[63:32];
               byteMask_d = {2{mask_q[7:4]}};
               waitCnt_d = `DC_T_WR - 4'h1 + ws;
               ret_d = S_PRE;
               state_d = S_WAIT;
            end
            S_READ: begin
               cmd = CMD_READ;
               addr_d = colMap(cur_q);
               byteMask_d = 8'h00;
               waitCnt_d = `DC_CL - 4'h1 + ws;
               ret_d = S_CAP0;
               state_d = S_WAIT;
            end
            S_CAP0: begin
               beat0_d = lmDataBusIn;
               state_d = S_CAP1;
            end
            S_CAP1: begin
               push = 1'b1;
               state_d = S_PRE;
            end
            S_PRE: begin
               cmd = CMD_PRE;
               addr_d = `DC_PRE_ALL;
               waitCnt_d = `DC_T_RP - 4'h1;
               ret_d = S_IDLE;
               state_d = S_WAIT;
            end
            S_WAIT: begin
               if (waitCnt_q <= 4'h1) begin
                  state_d = ret_q;
               end else begin
                  waitCnt_d = waitCnt_q - 4'h1;
               end
            end
            default: state_d = S_OFF;
         endcase
         // Chip stays deselected until the memory is started
         pins_d = (state_d == S_OFF) ? `DC_CMD_DESEL : cmdPins(cmd);
      end
      refCnt_d = refCnt_q;
      if (modeDone_q) begin
         refCnt_d = (refCnt_q == 9'h0) ? 9'(`DC_REFI_CYC - `DC_REF_SLACK) : refCnt_q - 9'h1;
      end
      // A new refresh deadline in the cycle of a refresh still counts
      refDue_d = (modeDone_q && refCnt_q == 9'h0) || (refDue_q && !refDone);
      pop = (fifoCount_q != 3'h0) && (!rdValid_q || rdReady);
      fifoCount_d = fifoCount_q + {2'h0, push} - {2'h0, pop};
      wrPtr_d = wrPtr_q + {1'b0, push};
      rdPtr_d = rdPtr_q + {1'b0, pop};
      rdValid_d = pop || (rdValid_q && !rdReady);
      ready_d = (divCnt_d == 3'h0) && state_d == S_IDLE && !refDue_d && renderLocal &&
         fifoCount_d < `DC_FIFO_DEPTH;
   end

   always_ff @(posedge ref_clk) begin
      freqSel_q <= freqSel_d;
      if (reset) begin
         state_q <= S_OFF;
         ret_q <= S_OFF;
         divCnt_q <= 3'h0;
         clk_q <= 1'b0;
         waitCnt_q <= 4'h0;
         initCnt_q <= 12'h0;
         refCnt_q <= 9'h0;
         refDue_q <= 1'b0;
         refLeft_q <= 2'h0;
         modeDone_q <= 1'b0;
         cur_q <= 20'h0;
         wrData_q <= 64'h0;
         mask_q <= 8'h0;
         beat0_q <= 32'h0;
         pins_q <= `DC_CMD_DESEL;
         addr_q <= 12'h0;
         dout_q <= 32'h0;
         oe_q <= 1'b0;
         byteMask_q <= 8'hff;
         ready_q <= 1'b0;
         fifoCount_q <= 3'h0;
         wrPtr_q <= 2'h0;
         rdPtr_q <= 2'h0;
         rdValid_q <= 1'b0;
      end else begin
         state_q <= state_d;
         ret_q <= ret_d;
         divCnt_q <= divCnt_d;
         clk_q <= clk_d;
         waitCnt_q <= waitCnt_d;
         initCnt_q <= initCnt_d;
         refCnt_q <= refCnt_d;
         refDue_q <= refDue_d;
         refLeft_q <= refLeft_d;
         modeDone_q <= modeDone_d;
         cur_q <= cur_d;
         wrData_q <= wrData_d;
         mask_q <= mask_d;
         beat0_q <= beat0_d;
         pins_q <= pins_d;
         addr_q <= addr_d;
         dout_q <= dout_d;
         oe_q <= oe_d;
         byteMask_q <= byteMask_d;
         ready_q <= ready_d;
         fifoCount_q <= fifoCount_d;
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
         rdValid_q <= rdValid_d;
      end
   end

   dc_line_buffer lineBuf (
      .clk(ref_clk),
      .wrEn(push),
      .wrAddr(wrPtr_q),
      .wrData({lmDataBusIn, beat0_q}),
      .rdEn(pop),
      .rdAddr(rdPtr_q),
      .rdData(rdData)
   );

   assign {lmChipSelectN, lmRowStrobeN, lmColStrobeN, lmWriteEnableN} = pins_q;
   assign lmAddrBus = addr_q;
   assign lmByteMask = byteMask_q;
   assign lmDataBusOut = dout_q;
   assign lmDataBusOe = oe_q;
   assign lmWriteClock = {clk_q, clk_q};
   assign lmReadTimingClock = clk_q;
   assign reqReady = ready_q;
   assign rdValid = rdValid_q;

   // System bus arbiter; alternates when both share it
   logic texGrant_q, texGrant_d, sysGrant_q, sysGrant_d, lastTex_q, lastTex_d;

   always_comb begin
      texGrant_d = texReq && (renderLocal || !renderSysReq || !lastTex_q);
      sysGrant_d = renderSysReq && !renderLocal && !texGrant_d;
      lastTex_d = texGrant_d ? 1'b1 : (sysGrant_d ? 1'b0 : lastTex_q);
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         texGrant_q <= 1'b0;
         sysGrant_q <= 1'b0;
         lastTex_q <= 1'b0;
      end else begin
         texGrant_q <= texGrant_d;
         sysGrant_q <= sysGrant_d;
         lastTex_q <= lastTex_d;
      end
   end

   assign texGrant = texGrant_q;
   assign renderSysGrant = sysGrant_q;

   // Time since last refresh on the pins
   logic [9:0] refAge_q;
   always_ff @(posedge ref_clk) begin
      if (reset || pins_q == `DC_CMD_REF || !modeDone_q) begin
         refAge_q <= 10'h0;
      end else begin
         refAge_q <= refAge_q + 10'h1;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   property p_mode_word;
      pins_q == `DC_CMD_MRS |-> addr_q[3:0] == 4'h1 && addr_q[6:4] == `DC_CL;
   endproperty
   a_mode_word: assert property (p_mode_word) else $error("mode word not sequential length two");

   property p_row_map;
      pins_q == `DC_CMD_ACT |-> addr_q[9:0] == cur_q[21:12] && addr_q[10] == cur_q[11] && addr_q[11] == cur_q[10];
   endproperty
   a_row_map: assert property (p_row_map) else $error("row address mapping wrong");

   property p_col_map;
      (pins_q == `DC_CMD_READ || pins_q == `DC_CMD_WRITE) |-> addr_q[7:0] == cur_q[9:2] && addr_q[11] == cur_q[10];
   endproperty
   a_col_map: assert property (p_col_map) else $error("column address mapping wrong");

   property p_refresh_age;
      refAge_q < 10'(`DC_REFI_CYC);
   endproperty
   a_refresh_age: assert property (p_refresh_age) else $error("refresh interval exceeded");

   property p_no_early_access;
      !modeDone_q |-> pins_q != `DC_CMD_ACT && pins_q != `DC_CMD_READ && pins_q != `DC_CMD_WRITE;
   endproperty
   a_no_early_access: assert property (p_no_early_access) else $error("access before init");

   property p_display_off;
      state_q == S_OFF && !displaySelect |=> state_q == S_OFF && lmChipSelectN;
   endproperty
   a_display_off: assert property (p_display_off) else $error("memory started while deselected");

   property p_strap;
      $fell(reset) |-> freqSel_q == $past(sbaStrap);
   endproperty
   a_strap: assert property (p_strap) else $error("strap not held from reset");

   property p_clocks;
      lmWriteClock[0] == lmWriteClock[1] && lmReadTimingClock == lmWriteClock[0];
   endproperty
   a_clocks: assert property (p_clocks) else $error("memory clocks disagree");

   property p_fifo_room;
      push |-> fifoCount_q < `DC_FIFO_DEPTH || pop;
   endproperty
   a_fifo_room: assert property (p_fifo_room) else $error("read buffer overflow");

   property p_share;
      texReq && renderSysReq && !renderLocal |=> texGrant_q ^ sysGrant_q;
   endproperty
   a_share: assert property (p_share) else $error("system bus not arbitrated");

   property p_local_render;
      renderLocal |=> !sysGrant_q;
   endproperty
   a_local_render: assert property (p_local_render) else $error("render granted system bus");

   property p_write_burst;
      pins_q == `DC_CMD_WRITE && $past(pins_q) != `DC_CMD_WRITE |-> oe_q ##1 oe_q [*3];
   endproperty
   a_write_burst: assert property (p_write_burst) else $error("write burst not two beats");
endmodule : display_cache_sdram_ctrl
`default_nettype wire

// File: tb/sdram_pair_model.sv
// Purpose: Behavioural row of 16-bit SDRAMs on the far side of the controller
// Assumes: Commands are taken on rising edges of the read timing clock
// Notes: Released data lines toggle every cycle instead of holding a value
`timescale 1ns/10ps
`default_nettype none
module sdram_pair_model (
   // Clocks
   input wire logic ref_clk,
   input wire logic memClk,
   // Command, address and masks
   input wire logic [3:0] cmdPins,
   input wire logic [11:0] addrPins,
   input wire logic [7:0] maskPins,
   // Data lines
   input wire logic [31:0] dqFromCtrl,
   input wire logic dqOe,
   output logic [31:0] dqToCtrl,
   // Observation
   output logic [15:0] cmdCount,
   output logic [15:0] refCount,
   output logic [15:0] protoErr,
   output logic [11:0] modeWord
);
   logic [31:0] mem [logic [19:0]];
   logic [10:0] rowOpen [2];
   logic [1:0] active = 2'h0;
   logic clkSeen = 1'b0;
   logic drv = 1'b0;
   logic wrNext = 1'b0;
   logic [31:0] outDq = 32'h0;
   logic [31:0] lastBus = 32'h0;
   logic [19:0] key;
   logic [19:0] rdKey;
   logic [19:0] wrKey;
   int rdCnt = -1;

   initial begin
      cmdCount = 16'h0;
      refCount = 16'h0;
      protoErr = 16'h0;
   end

   assign dqToCtrl = dqOe ? dqFromCtrl : (drv ? outDq : ~lastBus);

   function automatic logic [31:0] get(input logic [19:0] k);
      return mem.exists(k) ? mem[k] : 32'h0;
   endfunction : get

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] m);
      for (int i = 0; i < 4; i++) if (!m[i]) o[8*i +: 8] = n[8*i +: 8];
      return o;
   endfunction : merge

   always @(posedge ref_clk) begin
      lastBus <= dqToCtrl;
      if (memClk && !clkSeen) begin
         // Second beat of a burst of two wraps inside its aligned pair
         if (wrNext) mem[wrKey] = merge(get(wrKey), dqFromCtrl, maskPins[3:0]);
         wrNext = 1'b0;
         if (rdCnt >= 0) rdCnt = rdCnt - 1;
         drv <= (rdCnt == 1) || (rdCnt == 0);
         if (rdCnt == 1) outDq <= get(rdKey);
         if (rdCnt == 0) outDq <= get(rdKey ^ 20'h1);
         if (!cmdPins[3] && cmdPins != 4'h7) cmdCount <= cmdCount + 16'h1;
         key = {addrPins[11], rowOpen[addrPins[11]], addrPins[7:0]};
         case (cmdPins)
            4'h3: begin // Bank on line 11, eleven row bits
               if (active[addrPins[11]]) protoErr <= protoErr + 16'h1;
               active[addrPins[11]] = 1'b1;
               rowOpen[addrPins[11]] = addrPins[10:0];
            end
            4'h4, 4'h5: begin // Column lines 8 to 10 ignored
               if (!active[addrPins[11]]) protoErr <= protoErr + 16'h1;
               if (cmdPins[0]) begin
                  rdKey = key;
                  rdCnt = modeWord[6:4];
               end else begin
                  mem[key] = merge(get(key), dqFromCtrl, maskPins[3:0]);
                  wrKey = key ^ 20'h1;
                  wrNext = 1'b1;
               end
            end
            4'h2: active = addrPins[10] ? 2'h0 : active & ~(2'h1 << addrPins[11]);
            4'h1: begin // Refresh only with all banks closed
               if (active != 2'h0) protoErr <= protoErr + 16'h1;
               refCount <= refCount + 16'h1;
            end
            4'h0: begin // Mode word load
               if (active != 2'h0) protoErr <= protoErr + 16'h1;
               modeWord <= addrPins;
            end
            default: ;
         endcase
      end
      clkSeen <= memClk;
   end
endmodule : sdram_pair_model
`default_nettype wire

// File: tb/testbench.sv
// Purpose: Self-checking bench for the display cache SDRAM controller
// Assumes: Inputs change on the falling edge; outputs are read there
// Notes: Reads keep zero wait states because the memory latency is fixed by its mode word
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic sbaStrap = 1'b1;
   logic displaySelect = 1'b0;
   logic localMemPresent = 1'b1;
   logic renderLocal = 1'b1;
   logic [1:0] waitStates = 2'h0;
   logic reqValid = 1'b0;
   logic reqWrite = 1'b0;
   logic [21:2] reqAddr = 20'h0;
   logic [63:0] reqWrData = 64'h0;
   logic [7:0] reqMask = 8'h0;
   logic rdReady = 1'b0;
   logic texReq = 1'b0;
   logic renderSysReq = 1'b0;
   logic reqReady, rdValid, texGrant, renderSysGrant, lmDataBusOe, lmReadTimingClock;
   logic lmChipSelectN, lmRowStrobeN, lmColStrobeN, lmWriteEnableN;
   logic [63:0] rdData;
   logic [7:0] lmByteMask;
   logic [11:0] lmAddrBus, modeWord;
   logic [31:0] lmDataBusOut, lmDataBusIn;
   logic [1:0] lmWriteClock;
   logic [15:0] cmdCount, refCount, protoErr;
   logic [15:0] seed = 16'h2;
   logic [15:0] arbSeed = 16'h2;
   logic [19:0] curAddr = 20'h0;
   logic [7:0] curMask = 8'h0;
   logic [31:0] refMem [logic [19:0]];
   logic pTex = 1'b0, pRs = 1'b0, pLocal = 1'b1, wasBoth = 1'b0, lastTexG = 1'b0;
   logic [3:0] cmd;
   int quiet = 2;
   int rstCnt = 0;
   int bad_count = 0;
   int cmp_count = 0;

   assign cmd = {lmChipSelectN, lmRowStrobeN, lmColStrobeN, lmWriteEnableN};

   display_cache_sdram_ctrl display_cache_sdram_ctrl_inst (.ref_clk(ref_clk), .reset(reset), .sbaStrap(sbaStrap),
      .displaySelect(displaySelect), .localMemPresent(localMemPresent), .renderLocal(renderLocal),
      .waitStates(waitStates), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWrData(reqWrData),
      .reqMask(reqMask), .reqReady(reqReady), .rdValid(rdValid), .rdData(rdData), .rdReady(rdReady),
      .texReq(texReq), .renderSysReq(renderSysReq), .texGrant(texGrant), .renderSysGrant(renderSysGrant),
      .lmChipSelectN(lmChipSelectN), .lmRowStrobeN(lmRowStrobeN), .lmColStrobeN(lmColStrobeN),
      .lmWriteEnableN(lmWriteEnableN), .lmByteMask(lmByteMask), .lmAddrBus(lmAddrBus),
      .lmDataBusOut(lmDataBusOut), .lmDataBusOe(lmDataBusOe), .lmDataBusIn(lmDataBusIn),
      .lmWriteClock(lmWriteClock), .lmReadTimingClock(lmReadTimingClock));

   sdram_pair_model sdram_pair_model_inst (.ref_clk(ref_clk), .memClk(lmReadTimingClock), .cmdPins(cmd),
      .addrPins(lmAddrBus), .maskPins(lmByteMask), .dqFromCtrl(lmDataBusOut), .dqOe(lmDataBusOe),
      .dqToCtrl(lmDataBusIn), .cmdCount(cmdCount), .refCount(refCount), .protoErr(protoErr), .modeWord(modeWord));

   initial begin
      forever #20 ref_clk = ~ref_clk;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   function logic [15:0] rnd();
      seed = lfsr(seed);
      return seed;
   endfunction : rnd

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] m);
      for (int i = 0; i < 4; i++) if (!m[i]) o[8*i +: 8] = n[8*i +: 8];
      return o;
   endfunction : merge

   function automatic logic [31:0] old(input logic [19:0] a);
      return refMem.exists(a) ? refMem[a] : 32'h0;
   endfunction : old

   task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize

   task automatic issue(input logic w, input logic [19:0] a, input logic [63:0] d, input logic [7:0] m);
      int n;
      // Let an edge pass so back-to-back calls never drop and raise valid at once
      @(negedge ref_clk);
      reqWrite = w;
      reqAddr = a;
      reqWrData = d;
      reqMask = m;
      reqValid = 1'b1;
      n = 0;
      while (reqReady !== 1'b1 && n < 20000) begin
         @(negedge ref_clk);
         n++;
      end
      @(negedge ref_clk);
      reqValid = 1'b0;
   endtask : issue

   task automatic wr(input logic [19:0] a, input logic [63:0] d, input logic [7:0] m);
      refMem[a] = merge(old(a), d[31:0], m[3:0]);
      refMem[a ^ 20'h1] = merge(old(a ^ 20'h1), d[63:32], m[7:4]);
      waitStates = d[9:8];
      issue(1'b1, a, d, m);
   endtask : wr

   task automatic rd(input logic [19:0] a);
      int n;
      waitStates = 2'h0;
      issue(1'b0, a, 64'h0, 8'h0);
      n = 0;
      while (rdValid !== 1'b1 && n < 500) begin
         @(negedge ref_clk);
         n++;
      end
      repeat (2) @(negedge ref_clk);
      check({rdValid, rdData}, {1'b1, refMem[a ^ 20'h1], refMem[a]}, "read data");
      rdReady = 1'b1;
      @(negedge ref_clk);
      rdReady = 1'b0;
      check(rdValid, 1'b0, "read data released");
   endtask : rd

   task automatic period(input int exp);
      int t;
      logic last;
      t = 0;
      last = lmReadTimingClock;
      repeat (32) begin
         @(negedge ref_clk);
         if (lmReadTimingClock !== last) t++;
         last = lmReadTimingClock;
      end
      check(t >= 30 ? 2 : ((t >= 15 && t <= 16) ? 4 : 0), exp, "memory clock divide");
   endtask : period

   always @(posedge ref_clk) begin
      pTex <= texReq;
      pRs <= renderSysReq;
      pLocal <= renderLocal;
      // Track the request the design really took, not the one being queued
      if (reqValid && reqReady) begin
         curAddr <= reqAddr;
         curMask <= reqMask;
      end
   end

   // Pin watcher and random system bus requester
   always @(negedge ref_clk) begin
      check(lmWriteClock, {2{lmReadTimingClock}}, "clock copies");
      if (reset) begin
         if (rstCnt > 0) check({cmd, lmDataBusOe, lmByteMask, reqReady, rdValid, texGrant, renderSysGrant},
            {4'hf, 1'b0, 8'hff, 4'h0}, "reset state");
         rstCnt++;
         quiet = 2;
         wasBoth = 1'b0;
      end else begin
         rstCnt = 0;
         if (quiet > 0) quiet--;
         else if (pLocal || !(pTex && pRs)) check({texGrant, renderSysGrant}, {pTex, pRs && !pLocal}, "grant");
         else check({texGrant ^ renderSysGrant, wasBoth && texGrant == lastTexG}, 2'h2, "alternation");
         wasBoth = !pLocal && pTex && pRs;
         lastTexG = texGrant;
         if (cmd == 4'h3) check(lmAddrBus, {curAddr[8], curAddr[9], curAddr[19:10]}, "row phase");
         if (cmd[3:1] == 3'h2) check({lmAddrBus[11], lmAddrBus[7:0], lmDataBusOe, lmByteMask},
            {curAddr[8:0], !cmd[0], cmd[0] ? 8'h00 : {2{curMask[3:0]}}}, "column phase");
      end
      arbSeed = lfsr(arbSeed);
      texReq = arbSeed[0];
      renderSysReq = arbSeed[3];
   end

   initial begin
      logic [19:0] addrs [10];
      logic [63:0] d;
      int n;
      // Strap held steady across the reset edges
      repeat (8) @(negedge ref_clk);
      reset = 1'b0;
      n = 0;
      repeat (3000) begin
         @(negedge ref_clk);
         if (reqReady !== 1'b0) n++;
      end
      check({cmdCount, n != 0}, 17'h0, "idle while deselected");
      displaySelect = 1'b1;
      addrs[0] = 20'hfffff;
      addrs[1] = 20'h00100;
      addrs[2] = 20'h00601;
      for (int i = 3; i < 10; i++) begin
         d = {rnd(), rnd(), rnd(), rnd()};
         addrs[i] = d[19:0];
      end
      wr(addrs[0], {rnd(), rnd(), rnd(), rnd()}, 8'h00);
      check({modeWord, refCount >= 16'h2}, {12'h031, 1'b1}, "init sequence");
      period(2);
      n = refCount;
      repeat (1000) @(negedge ref_clk);
      check(refCount - n >= 3, 1'b1, "periodic refresh");
      foreach (addrs[i]) begin
         wr(addrs[i], {rnd(), rnd(), rnd(), rnd()}, 8'h00);
         rd(addrs[i]);
      end
      foreach (addrs[i]) rd(addrs[i]);
      for (int i = 0; i < 4; i++) begin
         d = {rnd(), rnd(), rnd(), rnd()};
         wr(addrs[i], d, d[23:16]);
         rd(addrs[i]);
      end
      renderLocal = 1'b0;
      reqValid = 1'b1;
      n = 0;
      repeat (300) begin
         @(negedge ref_clk);
         if (reqReady !== 1'b0) n++;
      end
      check(n, 0, "local requests held off");
      renderLocal = 1'b1;
      rd(addrs[1]);
      reset = 1'b1;
      sbaStrap = 1'b0;
      repeat (8) @(negedge ref_clk);
      reset = 1'b0;
      wr(addrs[3], {rnd(), rnd(), rnd(), rnd()}, 8'h00);
      rd(addrs[3]);
      period(4);
      check(protoErr, 16'h0, "memory protocol");
      summarize();
   end

   // Watchdog sized at several times the expected run length
   initial begin
      repeat (60000) @(posedge ref_clk);
      bad_count++;
      $display("wrong value at %0t: watchdog expired", $time);
      summarize();
   end
endmodule : testbench
`default_nettype wire
